// file: rtl/bper_params.svh
// Constants for the bridge data parity error reporting block.
// Assumes a single 20 MHz clock and a 32-bit AXI4-Lite register port.
//
// What this block does
// - Secondary master parity bit set only as secondary master, response on, error seen.
// - That bit sets only for downstream reads and writes erring on secondary.
// - Primary parity error pin driven only as primary write target or read initiator.
// - Primary parity error pin never asserted without primary parity response bit.
// - Primary pin asserts for primary errors, and forwarded secondary delayed write errors.
// - Secondary pin driven only as secondary write target or read initiator, response on.
// - Secondary pin asserts for secondary errors, and forwarded primary delayed write errors.
// - System error only for peer parity pin on posted writes toward target bus.
// - No parity system error when the bridge itself found it as target.
// - Posted write system error needs both parity response bits set.
// - Parity system error needs the system error enable bit.
// - System error stays high for reads, delayed writes and initiator-bus errors.
// - Asserting the system error output also sets the signaled system error bit.
`ifndef BPER_PARAMS_SVH
`define BPER_PARAMS_SVH

`define BPER_ADDR_W 4
`define BPER_OFF_CTRL 4'h0
`define BPER_OFF_STATUS 4'h4
`define BPER_OFF_MASK 4'h8

`define BPER_CTRL_P_RESP 0
`define BPER_CTRL_SERR_EN 1
`define BPER_CTRL_S_RESP 2
`define BPER_CTRL_W 3
`define BPER_CTRL_RST 3'h0

`define BPER_ST_S_MDPD 0
`define BPER_ST_SIG_SERR 1
`define BPER_ST_PRIMARY_PARITY_ERROR_N 2
`define BPER_ST_SECONDARY_PARITY_ERROR_N 3
`define BPER_ST_W 4
`define BPER_ST_RST 4'h0
`define BPER_MASK_RST 4'h0

`define BPER_RESP_OKAY 2'h0
`define BPER_RESP_DECERR 2'h3

`endif

// file: rtl/bper_pkg.sv
// Types shared by the parity error reporting block.
// Assumes the params header is compiled alongside.
`default_nettype none
package bper_pkg;
  typedef enum logic [1:0] {BPER_READ, BPER_POSTED, BPER_DELAYED} bper_kind_e;
  typedef enum logic {BPER_DOWN, BPER_UP} bper_dir_e;
  typedef enum logic [1:0] {BPER_IDLE, BPER_LOW, BPER_HIGH} bper_drv_e;

  // Transaction the bridge is carrying on one bus in this cycle.
  typedef struct packed {
    logic active;
    bper_kind_e kind;
    bper_dir_e dir;
    logic own_check;
  } bper_ctx_s;
endpackage : bper_pkg
`default_nettype wire

// file: rtl/bper_top.sv
// Data parity error reporting for a two-port bridge with an AXI4-Lite register port.
// Assumes the bridge core supplies per-bus transaction context on aclk and that the
// peer parity error pins are asynchronous and are synchronised here.
`default_nettype none
`include "bper_params.svh"
module bper_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`BPER_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`BPER_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire bper_pkg::bper_ctx_s prim_ctx,
  input wire bper_pkg::bper_ctx_s sec_ctx,
  input wire logic primary_parity_error_n_in,
  output logic primary_parity_error_n_out,
  output logic primary_parity_error_n_oe,
  input wire logic secondary_parity_error_n_in,
  output logic secondary_parity_error_n_out,
  output logic secondary_parity_error_n_oe,
  output logic primary_system_error_n_out,
  output logic primary_system_error_n_oe,
  output logic irq
);
  import bper_pkg::*;

  typedef struct packed {
    logic [1:0] p_sync;
    logic [1:0] s_sync;
    logic aw_held;
    logic [`BPER_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [`BPER_CTRL_W-1:0] ctrl;
    logic [`BPER_ST_W-1:0] status;
    logic [`BPER_ST_W-1:0] mask;
    bper_drv_e p_drv;
    bper_drv_e s_drv;
    logic serr_low;
    logic irq;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic p_out_n;
    logic p_oe;
    logic s_out_n;
    logic s_oe;
    logic serr_n;
  } bper_state_s;

  bper_state_s q;
  bper_state_s d;

  logic p_resp;
  logic s_resp;
  logic serr_en;
  logic p_pin;
  logic s_pin;
  logic p_err;
  logic s_err;
  logic s_mdpd_set;
  logic primary_parity_error_n_set;
  logic secondary_parity_error_n_set;
  logic serr_set;
  logic [`BPER_ST_W-1:0] st_set;
  logic [`BPER_ST_W-1:0] st_clr;
  logic wr_fire;
  logic [31:0] wmask;

  always_comb begin
    d = q;
    p_resp = q.ctrl[`BPER_CTRL_P_RESP];
    s_resp = q.ctrl[`BPER_CTRL_S_RESP];
    serr_en = q.ctrl[`BPER_CTRL_SERR_EN];

    // The pins are only read from the second stage, never the first.
    d.p_sync = {q.p_sync[0], ~primary_parity_error_n_in};
    d.s_sync = {q.s_sync[0], ~secondary_parity_error_n_in};
    p_pin = q.p_sync[1];
    s_pin = q.s_sync[1];

    // An error is seen on a bus by the bridge's own check or by the peer's pin.
    p_err = prim_ctx.active && (prim_ctx.own_check || p_pin);
    s_err = sec_ctx.active && (sec_ctx.own_check || s_pin);

    // Downstream traffic makes the bridge the master on the secondary bus.
    s_mdpd_set = s_resp && s_err && sec_ctx.dir == BPER_DOWN;

    // Own checks only: read initiator upstream, write target downstream.
    primary_parity_error_n_set = 1'b0;
    if (prim_ctx.active && prim_ctx.own_check) begin
      if (prim_ctx.kind == BPER_READ) begin
        primary_parity_error_n_set = prim_ctx.dir == BPER_UP;
      end else begin
        primary_parity_error_n_set = prim_ctx.dir == BPER_DOWN;
      end
    end
    // Target bus error on a downstream delayed write is sent back to the initiator.
    if (sec_ctx.active && s_pin && sec_ctx.kind == BPER_DELAYED &&
        sec_ctx.dir == BPER_DOWN && s_resp) begin
      primary_parity_error_n_set = 1'b1;
    end
    primary_parity_error_n_set = primary_parity_error_n_set && p_resp;

    secondary_parity_error_n_set = 1'b0;
    if (sec_ctx.active && sec_ctx.own_check) begin
      if (sec_ctx.kind == BPER_READ) begin
        secondary_parity_error_n_set = sec_ctx.dir == BPER_DOWN;
      end else begin
        secondary_parity_error_n_set = sec_ctx.dir == BPER_UP;
      end
    end
    if (prim_ctx.active && p_pin && prim_ctx.kind == BPER_DELAYED &&
        prim_ctx.dir == BPER_UP && p_resp) begin
      secondary_parity_error_n_set = 1'b1;
    end
    secondary_parity_error_n_set = secondary_parity_error_n_set && s_resp;

    // Only a peer pin on the target bus of a posted write counts; own checks never do.
    serr_set = 1'b0;
    if (prim_ctx.active && p_pin && !prim_ctx.own_check &&
        prim_ctx.kind == BPER_POSTED && prim_ctx.dir == BPER_UP) begin
      serr_set = 1'b1;
    end
    if (sec_ctx.active && s_pin && !sec_ctx.own_check &&
        sec_ctx.kind == BPER_POSTED && sec_ctx.dir == BPER_DOWN) begin
      serr_set = 1'b1;
    end
    serr_set = serr_set && p_resp && s_resp;
    serr_set = serr_set && serr_en;

    // A parity pin is driven low for each erring cycle, then high one cycle, then released.
    case (q.p_drv)
      BPER_IDLE: begin
        if (primary_parity_error_n_set) begin
          d.p_drv = BPER_LOW;
        end
      end
      BPER_LOW: begin
        d.p_drv = primary_parity_error_n_set ? BPER_LOW : BPER_HIGH;
      end
      BPER_HIGH: begin
        d.p_drv = primary_parity_error_n_set ? BPER_LOW : BPER_IDLE;
      end
      default: begin
        d.p_drv = BPER_IDLE;
      end
    endcase
    case (q.s_drv)
      BPER_IDLE: begin
        if (secondary_parity_error_n_set) begin
          d.s_drv = BPER_LOW;
        end
      end
      BPER_LOW: begin
        d.s_drv = secondary_parity_error_n_set ? BPER_LOW : BPER_HIGH;
      end
      BPER_HIGH: begin
        d.s_drv = secondary_parity_error_n_set ? BPER_LOW : BPER_IDLE;
      end
      default: begin
        d.s_drv = BPER_IDLE;
      end
    endcase
    // The system error line is open drain, so it is only ever pulled low.
    d.serr_low = serr_set;

    // Write channel: address and data may arrive in either order.
    if (s_axi_awvalid && !q.aw_held) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_held) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    wr_fire = q.aw_held && q.w_held && !q.bvalid;
    wmask = {{8{q.w_strb[3]}}, {8{q.w_strb[2]}}, {8{q.w_strb[1]}}, {8{q.w_strb[0]}}};
    st_clr = '0;
    if (wr_fire) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `BPER_RESP_OKAY;
      case (q.aw_addr)
        `BPER_OFF_CTRL: begin
          d.ctrl = (q.ctrl & ~wmask[`BPER_CTRL_W-1:0]) |
                   (q.w_data[`BPER_CTRL_W-1:0] & wmask[`BPER_CTRL_W-1:0]);
        end
        `BPER_OFF_STATUS: begin
          st_clr = q.w_data[`BPER_ST_W-1:0] & wmask[`BPER_ST_W-1:0];
        end
        `BPER_OFF_MASK: begin
          d.mask = (q.mask & ~wmask[`BPER_ST_W-1:0]) |
                   (q.w_data[`BPER_ST_W-1:0] & wmask[`BPER_ST_W-1:0]);
        end
        default: begin
          d.bresp = `BPER_RESP_DECERR;
        end
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Read channel: one cycle from address to data.
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = `BPER_RESP_OKAY;
      d.rdata = '0;
      case (s_axi_araddr)
        `BPER_OFF_CTRL: begin
          d.rdata[`BPER_CTRL_W-1:0] = q.ctrl;
        end
        `BPER_OFF_STATUS: begin
          d.rdata[`BPER_ST_W-1:0] = q.status;
        end
        `BPER_OFF_MASK: begin
          d.rdata[`BPER_ST_W-1:0] = q.mask;
        end
        default: begin
          d.rresp = `BPER_RESP_DECERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // A new event in the clearing cycle survives, since set wins.
    st_set = '0;
    st_set[`BPER_ST_S_MDPD] = s_mdpd_set;
    st_set[`BPER_ST_SIG_SERR] = serr_set;
    st_set[`BPER_ST_PRIMARY_PARITY_ERROR_N] = primary_parity_error_n_set;
    st_set[`BPER_ST_SECONDARY_PARITY_ERROR_N] = secondary_parity_error_n_set;
    d.status = (q.status & ~st_clr) | st_set;
    d.irq = |(d.status & d.mask);

    // Pins and ready flags leave straight from flops, so no decode glitch reaches a pad.
    d.aw_rdy = !d.aw_held;
    d.w_rdy = !d.w_held;
    d.ar_rdy = !d.rvalid;
    d.p_out_n = d.p_drv != BPER_LOW;
    d.p_oe = d.p_drv != BPER_IDLE;
    d.s_out_n = d.s_drv != BPER_LOW;
    d.s_oe = d.s_drv != BPER_IDLE;
    d.serr_n = !d.serr_low;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= `BPER_CTRL_RST;
      q.status <= `BPER_ST_RST;
      q.mask <= `BPER_MASK_RST;
      q.p_drv <= BPER_IDLE;
      q.s_drv <= BPER_IDLE;
      q.aw_rdy <= 1'b1;
      q.w_rdy <= 1'b1;
      q.ar_rdy <= 1'b1;
      q.p_out_n <= 1'b1;
      q.s_out_n <= 1'b1;
      q.serr_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.aw_rdy;
  assign s_axi_wready = q.w_rdy;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.ar_rdy;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign primary_parity_error_n_out = q.p_out_n;
  assign primary_parity_error_n_oe = q.p_oe;
  assign secondary_parity_error_n_out = q.s_out_n;
  assign secondary_parity_error_n_oe = q.s_oe;
  assign primary_system_error_n_out = q.serr_n;
  assign primary_system_error_n_oe = q.serr_low;
  assign irq = q.irq;
endmodule : bper_top
`default_nettype wire

// file: verif/bper_pci_agent.sv
// Far side agent of one bus: pulls its parity error line low on request.
// Assumes a pull-up on the line, shared with the bridge's enabled driver.
`default_nettype none
module bper_pci_agent (
  input wire logic aclk,
  input wire logic err_req,
  input wire logic dut_out,
  input wire logic dut_oe,
  output logic pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drive_q;
  // The line moves only just after an edge, as a real agent's would.
  always_ff @(posedge aclk) drive_q <= err_req;
  // The pull-up wins when nobody drives, so a released line never reads stale.
  assign pin_n = !(drive_q || (dut_oe && !dut_out));
endmodule : bper_pci_agent
`default_nettype wire

// file: verif/bper_top_sva.sv
// Checker for bper_top: causes and shape of the parity and system error pins.
// Assumes it is bound into bper_top and sees only its ports.
`default_nettype none
module bper_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire bper_pkg::bper_ctx_s prim_ctx,
  input wire bper_pkg::bper_ctx_s sec_ctx,
  input wire logic primary_parity_error_n_out,
  input wire logic primary_parity_error_n_oe,
  input wire logic secondary_parity_error_n_out,
  input wire logic secondary_parity_error_n_oe,
  input wire logic primary_system_error_n_out,
  input wire logic primary_system_error_n_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import bper_pkg::*;
  logic pc, sc, ec;
  // Enable bits are invisible here, so only the transfer side of each cause is checked.
  assign pc = prim_ctx.active && prim_ctx.own_check
    && (prim_ctx.kind == BPER_READ) == (prim_ctx.dir == BPER_UP)
    || sec_ctx.active && sec_ctx.kind == BPER_DELAYED && sec_ctx.dir == BPER_DOWN;
  assign sc = sec_ctx.active && sec_ctx.own_check
    && (sec_ctx.kind == BPER_READ) == (sec_ctx.dir == BPER_DOWN)
    || prim_ctx.active && prim_ctx.kind == BPER_DELAYED && prim_ctx.dir == BPER_UP;
  assign ec = prim_ctx.active && prim_ctx.kind == BPER_POSTED && !prim_ctx.own_check
    && prim_ctx.dir == BPER_UP || sec_ctx.active && sec_ctx.kind == BPER_POSTED
    && !sec_ctx.own_check && sec_ctx.dir == BPER_DOWN;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_P_CAUSE: assert property (!primary_parity_error_n_out |-> $past(pc))
    else $error("primary parity low without cause");
  AST_P_HOLD: assert property (!primary_parity_error_n_out |->
    primary_parity_error_n_oe ##1 primary_parity_error_n_oe)
    else $error("primary parity not driven");
  AST_P_REL: assert property (primary_parity_error_n_oe && primary_parity_error_n_out |=>
    !primary_parity_error_n_oe || !primary_parity_error_n_out)
    else $error("primary held");
  AST_S_CAUSE: assert property (!secondary_parity_error_n_out |-> $past(sc))
    else $error("secondary parity low without cause");
  AST_S_HOLD: assert property (!secondary_parity_error_n_out |->
    secondary_parity_error_n_oe ##1 secondary_parity_error_n_oe)
    else $error("secondary parity not driven");
  AST_S_REL: assert property (
    secondary_parity_error_n_oe && secondary_parity_error_n_out |=>
    !secondary_parity_error_n_oe || !secondary_parity_error_n_out)
    else $error("secondary held");
  AST_E_CAUSE: assert property (
    !primary_system_error_n_out |-> $past(ec))
    else $error("system error without cause");
  AST_E_OD: assert property (primary_system_error_n_oe != primary_system_error_n_out)
    else $error("system error drive mismatch");
endmodule : bper_top_sva
bind bper_top bper_top_sva u_sva (.aclk, .aresetn, .prim_ctx, .sec_ctx,
  .primary_parity_error_n_out, .primary_parity_error_n_oe, .secondary_parity_error_n_out,
  .secondary_parity_error_n_oe, .primary_system_error_n_out, .primary_system_error_n_oe);
`default_nettype wire

// file: verif/tb_bridge_parity_error_reporting.sv
// Bench for bper_top: every parity case, register port and interrupt.
// Assumes agents with pull-ups stand on both parity lines.
`default_nettype none
`include "bper_params.svh"
module tb_bridge_parity_error_reporting;
  timeunit 1ns;
  timeprecision 1ns;
  import bper_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  bper_ctx_s prim_ctx = '0, sec_ctx = '0;
  logic p_req = 1'b0, s_req = 1'b0, primary_parity_error_n_in, secondary_parity_error_n_in;
  logic primary_parity_error_n_out, primary_parity_error_n_oe, primary_system_error_n_out;
  logic secondary_parity_error_n_out, secondary_parity_error_n_oe, primary_system_error_n_oe;
  int err_total = 0, n_tests = 0;
  logic [3:0] pins;
  logic [7:0] lfsr = 8'h1b;
  always #25 aclk = !aclk;
  bper_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .prim_ctx, .sec_ctx, .primary_parity_error_n_in, .primary_parity_error_n_out,
    .primary_parity_error_n_oe, .secondary_parity_error_n_in, .secondary_parity_error_n_out,
    .secondary_parity_error_n_oe, .primary_system_error_n_out, .primary_system_error_n_oe, .irq);
  bper_pci_agent u_pa (.aclk, .err_req(p_req), .dut_out(primary_parity_error_n_out),
    .dut_oe(primary_parity_error_n_oe), .pin_n(primary_parity_error_n_in));
  bper_pci_agent u_sa (.aclk, .err_req(s_req), .dut_out(secondary_parity_error_n_out),
    .dut_oe(secondary_parity_error_n_oe), .pin_n(secondary_parity_error_n_in));
  function automatic logic [7:0] nxt(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  function automatic logic [3:0] expect_st(bper_ctx_s x, logic sec, logic [2:0] c);
    logic rk, dn, dw;
    rk = x.kind == BPER_READ;
    dn = x.dir == BPER_DOWN;
    dw = x.kind == BPER_DELAYED && !x.own_check;
    expect_st[0] = sec && dn && c[2];
    expect_st[1] = x.kind == BPER_POSTED && !x.own_check && &c && sec == dn;
    expect_st[2] = c[0] && (sec ? dw && dn && c[2] : x.own_check && rk != dn);
    expect_st[3] = c[2] && (sec ? x.own_check && rk == dn : dw && !dn && c[0]);
  endfunction : expect_st
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic wr(logic [3:0] a, logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask : wr
  task automatic rd(logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task automatic ev(bper_ctx_s x, logic sec);
    p_req <= !sec && !x.own_check;
    s_req <= sec && !x.own_check;
    // The line must cross the synchroniser before the transfer is shown.
    repeat (3) @(posedge aclk);
    if (sec) sec_ctx <= x;
    else prim_ctx <= x;
    @(posedge aclk);
    {prim_ctx, sec_ctx, p_req, s_req} <= '0;
    // The answer stands for one cycle after the causing edge, so it is taken at the next edge.
    @(posedge aclk);
    pins = {primary_system_error_n_oe, !primary_system_error_n_out,
      !secondary_parity_error_n_out, !primary_parity_error_n_out};
    repeat (5) @(posedge aclk);
  endtask : ev
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] c, j;
    logic [3:0] m, e;
    bper_ctx_s x;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check("idle p oe", primary_parity_error_n_oe, 1'b0);
    check("idle s oe", secondary_parity_error_n_oe, 1'b0);
    check("idle serr", primary_system_error_n_out, 1'b1);
    for (int a = 0; a < 16; a += 4) begin
      rd(4'(a), d, r);
      check("reset value", d, 32'h0);
      check("read resp", r, a == 12 ? `BPER_RESP_DECERR : `BPER_RESP_OKAY);
    end
    wr(4'hc, 32'hffffffff, r);
    check("unmapped write", r, `BPER_RESP_DECERR);
    for (int i = 0; i < 48; i++) begin
      lfsr = nxt(lfsr);
      j = 3'((i % 24) / 3);
      c = i < 24 ? 3'h7 : lfsr[2:0];
      m = lfsr[6:3];
      x = '{1'b1, bper_kind_e'(2'(i % 3)), bper_dir_e'(j[0]), j[2]};
      wr(`BPER_OFF_CTRL, {29'h0, c}, r);
      wr(`BPER_OFF_MASK, {28'h0, m}, r);
      wr(`BPER_OFF_STATUS, 32'hf, r);
      ev(x, j[1]);
      e = expect_st(x, j[1], c);
      rd(`BPER_OFF_STATUS, d, r);
      check("master bit", d[0], e[0]);
      check("system bit", d[1], e[1]);
      check("pin bits", d[3:2], e[3:2]);
      check("pins", pins, {e[1], e[1], e[3], e[2]});
      check("irq", irq, |(e & m));
    end
    rd(`BPER_OFF_CTRL, d, r);
    check("ctrl", d, c);
    wr(`BPER_OFF_STATUS, 32'hf, r);
    repeat (2) @(posedge aclk);
    check("irq cleared", irq, 1'b0);
    end_sim();
  end
  // Roughly five times the expected run of some 1000 cycles.
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    end_sim();
  end
endmodule : tb_bridge_parity_error_reporting
`default_nettype wire
